/* File: hw/rco_cfg.svh */
// offsets, field positions, reset values of the reference clock output
`ifndef RCO_CFG_SVH
`define RCO_CFG_SVH
`define RCO_ADR_W 8
`define RCO_CTRL_ADR 8'h00
`define RCO_SRC_ADR 8'h04
`define RCO_STAT_ADR 8'h08
`define RCO_EN_BIT 7
`define RCO_DUTY_HI 4
`define RCO_DUTY_LO 3
`define RCO_DIV_HI 2
`define RCO_DIV_LO 0
`define RCO_SRCSEL_HI 3
`define RCO_SRCSEL_LO 0
`define RCO_STAT_RUN_BIT 0
`define RCO_STAT_LVL_BIT 1
`define RCO_EN_RST 1'b0
`define RCO_DUTY_RST 2'h2
`define RCO_DUTY_ZERO 2'h0
`define RCO_DIV_RST 3'h0
`define RCO_DIV_BYPASS 3'h0
`define RCO_SRCSEL_RST 4'h0
`define RCO_SRC_COUNT 10
`define RCO_SRC_FIRST_RSVD 4'hA
`endif

/* File: hw/rco_pkg.sv */
// types of the reference clock output
package rco_pkg;
  typedef logic [2:0] rco_div_t;
  typedef logic [1:0] rco_duty_t;
  typedef logic [3:0] rco_src_t;
  typedef logic [7:0] rco_cnt_t;
  typedef enum logic {RCO_IDLE, RCO_RUN} rco_gen_state_t;
endpackage

/* File: hw/rco_gen_if.sv */
// settings and state passed between register file and generator
`timescale 1ns/1ps
interface rco_gen_if import rco_pkg::*; ();
  logic enable;
  rco_div_t divider;
  rco_duty_t duty;
  rco_src_t source;
  logic running;
  logic level;
  modport regs (output enable, output divider, output duty,
    output source, input running, input level);
  modport gen (input enable, input divider, input duty,
    output running, output level);
endinterface

/* File: hw/rco_wb_regs.sv */
// wishbone classic register file of the reference clock output
`timescale 1ns/1ps
`include "rco_cfg.svh"
module rco_wb_regs import rco_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`RCO_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  rco_gen_if.regs gif
);
  // ************************************************
  // bus handshake
  // ************************************************
  logic req;
  logic wr;
  logic [31:0] next_rdata;

  assign req = wb_cyc_i && wb_stb_i;
  assign wr = req && wb_ack_o && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    case (wb_adr_i)
      `RCO_CTRL_ADR: begin
        next_rdata[`RCO_EN_BIT] = gif.enable;
        next_rdata[`RCO_DUTY_HI:`RCO_DUTY_LO] = gif.duty;
        next_rdata[`RCO_DIV_HI:`RCO_DIV_LO] = gif.divider;
      end
      `RCO_SRC_ADR: begin
        next_rdata[`RCO_SRCSEL_HI:`RCO_SRCSEL_LO] = gif.source;
      end
      `RCO_STAT_ADR: begin
        next_rdata[`RCO_STAT_RUN_BIT] = gif.running;
        next_rdata[`RCO_STAT_LVL_BIT] = gif.level;
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (req && !wb_ack_o) begin
      wb_dat_o <= next_rdata;
    end
  end

  // ************************************************
  // control and source select
  // ************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gif.enable <= `RCO_EN_RST;
      gif.duty <= `RCO_DUTY_RST;
      gif.divider <= `RCO_DIV_RST;
    end else if (wr && wb_adr_i == `RCO_CTRL_ADR) begin
      gif.enable <= wb_dat_i[`RCO_EN_BIT];
      gif.duty <= wb_dat_i[`RCO_DUTY_HI:`RCO_DUTY_LO];
      gif.divider <= wb_dat_i[`RCO_DIV_HI:`RCO_DIV_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gif.source <= `RCO_SRCSEL_RST;
    end else if (wr && wb_adr_i == `RCO_SRC_ADR) begin
      gif.source <= wb_dat_i[`RCO_SRCSEL_HI:`RCO_SRCSEL_LO];
    end
  end
endmodule

/* File: hw/rco_divider.sv */
// divider and duty shaper driven by edges of the chosen source
`timescale 1ns/1ps
`include "rco_cfg.svh"
module rco_divider import rco_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic src_level_i,
  input wire logic src_rise_i,
  input wire logic src_edge_i,
  output logic out_o,
  rco_gen_if.gen gif
);
  // ************************************************
  // phase counter in half source periods
  // ************************************************
  rco_gen_state_t state;
  rco_cnt_t cnt;
  rco_cnt_t mask;
  rco_cnt_t th;

  assign mask = rco_cnt_t'((9'h002 << gif.divider) - 9'h001);
  assign th = rco_cnt_t'(({7'h00, gif.duty} << gif.divider) >> 1);
  assign gif.running = (state == RCO_RUN);
  assign gif.level = out_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= RCO_IDLE;
    end else begin
      case (state)
        RCO_IDLE: begin
          if (gif.enable && src_rise_i) begin
            state <= RCO_RUN;
          end
        end
        RCO_RUN: begin
          if (!gif.enable) begin
            state <= RCO_IDLE;
          end
        end
        default: begin
          state <= RCO_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state != RCO_RUN) begin
      cnt <= 8'h00;
    end else if (src_edge_i) begin
      cnt <= (cnt + 8'h01) & mask;
    end
  end

  // ************************************************
  // output shaping
  // ************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_o <= 1'b0;
    end else if (!gif.enable) begin
      out_o <= 1'b0;
    end else if (gif.divider == `RCO_DIV_BYPASS) begin
      out_o <= src_level_i && (state == RCO_RUN || src_rise_i);
    end else if (state != RCO_RUN) begin
      out_o <= 1'b0;
    end else begin
      out_o <= (cnt < th);
    end
  end

  // ************************************************
  // checks
  // ************************************************
  property p_wrap;
    @(posedge clk_i) disable iff (rst_i)
    (state == RCO_RUN && gif.enable && src_edge_i && cnt == mask)
      |=> (cnt == 8'h00);
  endproperty
  a_wrap: assert property (p_wrap) else $error("phase did not wrap");

  property p_high_time;
    @(posedge clk_i) disable iff (rst_i)
    (gif.enable && state == RCO_RUN && gif.divider != `RCO_DIV_BYPASS)
      |=> (out_o == ($past(cnt) < $past(th)));
  endproperty
  a_high_time: assert property (p_high_time)
    else $error("bad high time");

  property p_live_change;
    @(posedge clk_i) disable iff (rst_i)
    (gif.enable && state == RCO_RUN && $changed(gif.divider))
      |=> (state == RCO_RUN);
  endproperty
  a_live_change: assert property (p_live_change)
    else $error("stopped on change");
endmodule

/* File: hw/rco_top.sv */
// reference clock output: source select, divider, duty, register bus
// ************************************************
// ************************************************
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "rco_cfg.svh"
module rco_top import rco_pkg::*; #(
  parameter int NUM_SRC = `RCO_SRC_COUNT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`RCO_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sys_clk_i,
  input wire logic fast_internal_osc_i,
  input wire logic slow_internal_osc_i,
  input wire logic medium_internal_osc_i,
  input wire logic secondary_osc_i,
  input wire logic numeric_osc_output_i,
  input wire logic logic_cell_one_output_i,
  input wire logic logic_cell_two_output_i,
  input wire logic logic_cell_three_output_i,
  input wire logic logic_cell_four_output_i,
  output logic refout_pin_o,
  output logic signal_modulator_clk_o
);
  // ************************************************
  // decoding helpers
  // ************************************************
  function automatic logic src_reserved(input rco_src_t s);
    src_reserved = (s >= `RCO_SRC_FIRST_RSVD);
  endfunction

  function automatic logic src_pick(input logic [NUM_SRC-1:0] v,
    input rco_src_t s);
    logic r;
    r = 1'b0;
    if (!src_reserved(s) && int'(s) < NUM_SRC) begin
      r = v[s];
    end
    src_pick = r;
  endfunction

  // ************************************************
  // settings shared by registers and generator
  // ************************************************
  rco_gen_if gif ();

  rco_wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .gif(gif)
  );

  // ************************************************
  // source collection and synchronisers
  // ************************************************
  logic [NUM_SRC-1:0] src_raw;
  logic [NUM_SRC-1:0] sync1;
  logic [NUM_SRC-1:0] sync2;
  logic [9:0] src_pins;

  assign src_pins = {logic_cell_four_output_i, logic_cell_three_output_i,
    logic_cell_two_output_i, logic_cell_one_output_i,
    numeric_osc_output_i, secondary_osc_i, medium_internal_osc_i,
    slow_internal_osc_i, fast_internal_osc_i, sys_clk_i};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi = gi + 1) begin : g_src
      if (gi < 10) begin : g_pin
        assign src_raw[gi] = src_pins[gi];
      end else begin : g_none
        assign src_raw[gi] = 1'b0;
      end
      // no low-power gating anywhere on the source path
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= src_raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  // ************************************************
  // selected source and its edges
  // ************************************************
  logic sel_level;
  logic sel_q;
  logic sel_rise;
  logic sel_edge;

  assign sel_level = src_pick(sync2, gif.source);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q <= 1'b0;
    end else begin
      sel_q <= sel_level;
    end
  end

  assign sel_rise = sel_level && !sel_q;
  assign sel_edge = sel_level ^ sel_q;

  // ************************************************
  // generator
  // ************************************************
  logic gen_out;

  rco_divider u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_level_i(sel_level),
    .src_rise_i(sel_rise),
    .src_edge_i(sel_edge),
    .out_o(gen_out),
    .gif(gif)
  );

  // one flop feeds both the pin and the modulator tap
  assign refout_pin_o = gen_out;
  assign signal_modulator_clk_o = gen_out;

  // ************************************************
  // checks
  // ************************************************
  sequence s_idle_then_rise;
    !gif.running ##1 (gif.enable && sel_rise);
  endsequence

  sequence s_idle_no_rise;
    !gif.running && !sel_rise;
  endsequence

  property p_start;
    @(posedge clk_i) disable iff (rst_i)
    s_idle_then_rise |=> gif.running;
  endproperty
  a_start: assert property (p_start) else $error("no start on edge");

  property p_no_early_start;
    @(posedge clk_i) disable iff (rst_i)
    s_idle_no_rise |=> !gif.running;
  endproperty
  a_no_early_start: assert property (p_no_early_start)
    else $error("started without edge");

  property p_first_high;
    @(posedge clk_i) disable iff (rst_i)
    $rose(refout_pin_o) |-> $past(gif.enable)
      && ($past(gif.running) || $past(sel_rise));
  endproperty
  a_first_high: assert property (p_first_high)
    else $error("runt high");

  property p_stop_now;
    @(posedge clk_i) disable iff (rst_i)
    !gif.enable |=> !refout_pin_o && !gif.running;
  endproperty
  a_stop_now: assert property (p_stop_now) else $error("late stop");

  property p_duty_zero;
    @(posedge clk_i) disable iff (rst_i)
    (gif.duty == `RCO_DUTY_ZERO && gif.divider != `RCO_DIV_BYPASS)
      |=> !refout_pin_o;
  endproperty
  a_duty_zero: assert property (p_duty_zero)
    else $error("high at zero");

  property p_pass;
    @(posedge clk_i) disable iff (rst_i)
    (gif.enable && gif.running && gif.divider == `RCO_DIV_BYPASS)
      |=> (refout_pin_o == $past(sel_level));
  endproperty
  a_pass: assert property (p_pass) else $error("bypass wrong");

  property p_reset_vals;
    @(posedge clk_i)
    rst_i |=> gif.duty == `RCO_DUTY_RST && gif.enable == `RCO_EN_RST
      && !refout_pin_o;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("bad reset");

  property p_enable_write;
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `RCO_CTRL_ADR)
      |=> gif.enable == $past(wb_dat_i[`RCO_EN_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable not written");

  property p_reserved_quiet;
    @(posedge clk_i) disable iff (rst_i)
    (src_reserved(gif.source) && !gif.running) |=> !gif.running;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet)
    else $error("reserved source ran");

  property p_ctrl_zero_bits;
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && !wb_we_i && wb_adr_i == `RCO_CTRL_ADR)
      |-> wb_dat_o[6:5] == 2'h0 && wb_dat_o[31:8] == 24'h000000;
  endproperty
  a_ctrl_zero_bits: assert property (p_ctrl_zero_bits)
    else $error("control pad bits set");

  property p_src_zero_bits;
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && !wb_we_i && wb_adr_i == `RCO_SRC_ADR)
      |-> wb_dat_o[31:4] == 28'h0000000;
  endproperty
  a_src_zero_bits: assert property (p_src_zero_bits)
    else $error("select pad bits set");

  property p_taps_match;
    @(posedge clk_i) disable iff (rst_i)
    $changed(gen_out) |-> refout_pin_o == signal_modulator_clk_o;
  endproperty
  a_taps_match: assert property (p_taps_match)
    else $error("taps differ");

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held");

  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o)
      |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("request not answered");

  sequence s_ctrl_write;
    wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
      && wb_adr_i == `RCO_CTRL_ADR;
  endsequence

  property p_duty_write;
    @(posedge clk_i) disable iff (rst_i)
    s_ctrl_write |=> gif.duty == $past(wb_dat_i[`RCO_DUTY_HI:`RCO_DUTY_LO]);
  endproperty
  a_duty_write: assert property (p_duty_write)
    else $error("duty not written");

  property p_div_write;
    @(posedge clk_i) disable iff (rst_i)
    s_ctrl_write |=> gif.divider == $past(wb_dat_i[`RCO_DIV_HI:`RCO_DIV_LO]);
  endproperty
  a_div_write: assert property (p_div_write)
    else $error("divider not written");

  property p_src_write;
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
      && wb_adr_i == `RCO_SRC_ADR)
      |=> gif.source == $past(wb_dat_i[`RCO_SRCSEL_HI:`RCO_SRCSEL_LO]);
  endproperty
  a_src_write: assert property (p_src_write)
    else $error("source not written");

  property p_sel_masked;
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && !wb_sel_i[0])
      |=> $stable(gif.enable) && $stable(gif.duty)
        && $stable(gif.divider) && $stable(gif.source);
  endproperty
  a_sel_masked: assert property (p_sel_masked)
    else $error("masked write landed");

  property p_reserved_low;
    @(posedge clk_i) disable iff (rst_i)
    (src_reserved(gif.source) && !gif.running) |=> !refout_pin_o;
  endproperty
  a_reserved_low: assert property (p_reserved_low)
    else $error("reserved source drove pin");
endmodule

/* File: tb/rco_far_side.sv */
// source clocks feeding the reference clock output
`timescale 1ns/1ps
module rco_far_side #(
  parameter int BASE_HALF = 3
) (
  output logic [9:0] src_o
);
  // ****
  // free-running sources, half period BASE_HALF plus code clk cycles
  // ****
  for (genvar g = 0; g < 10; g++) begin : gen_src
    initial begin
      src_o[g] = 1'b0;
      #1;
      forever #((BASE_HALF + g) * 4) src_o[g] = ~src_o[g];
    end
  end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench of the reference clock output
`timescale 1ns/1ps
`include "rco_cfg.svh"
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic pin;
  logic tap;
  logic [9:0] src;
  logic tap_bad = 1'b0;
  int err_total = 0;
  int total_checks = 0;
  int cyc_cnt = 0;

  always #2 clk_i = ~clk_i;

  rco_far_side rco_far_side_i (.src_o(src));

  rco_top rco_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sys_clk_i(src[0]),
    .fast_internal_osc_i(src[1]), .slow_internal_osc_i(src[2]),
    .medium_internal_osc_i(src[3]), .secondary_osc_i(src[4]),
    .numeric_osc_output_i(src[5]), .logic_cell_one_output_i(src[6]),
    .logic_cell_two_output_i(src[7]), .logic_cell_three_output_i(src[8]),
    .logic_cell_four_output_i(src[9]), .refout_pin_o(pin),
    .signal_modulator_clk_o(tap)
  );

  always @(posedge clk_i) begin
    if (tap !== pin) tap_bad <= 1'b1;
  end

  // ****
  // helpers
  // ****
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    check(n < 20, "no bus answer");
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q === e, "read value");
  endtask

  task automatic cfg(input int s, input int du, input int dv);
    wr(`RCO_CTRL_ADR, {24'h0, 3'b000, du[1:0], dv[2:0]});
    wr(`RCO_SRC_ADR, {28'h0, s[3:0]});
    wr(`RCO_CTRL_ADR, {24'h0, 3'b100, du[1:0], dv[2:0]});
  endtask

  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk_i);
      if (pin !== 1'b0) seen = 1'b1;
    end
    check(seen === 1'b0, "output not held low");
  endtask

  task automatic meas(output int hi, output int per);
    int n;
    n = 0;
    hi = 0;
    per = 0;
    while (pin !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    while (pin === 1'b1 && hi < 3000) begin
      @(posedge clk_i);
      hi++;
    end
    while (pin === 1'b0 && per < 3000) begin
      @(posedge clk_i);
      per++;
    end
    per += hi;
  endtask

  task automatic wave(input int s, input int du, input int dv);
    int h, eh, ep, hi, per;
    h = 3 + s;
    eh = (dv == 0) ? h : du * (1 << dv) / 2 * h;
    ep = (dv == 0) ? 2 * h : 2 * (1 << dv) * h;
    cfg(s, du, dv);
    if (eh == 0) begin
      quiet(300);
    end else begin
      meas(hi, per);
      check(hi == eh, "first high time");
      meas(hi, per);
      check(hi == eh && per == ep, "high time or period");
    end
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_regs();
    rd(`RCO_CTRL_ADR, 32'h10);
    rd(`RCO_SRC_ADR, 32'h0);
    rd(8'h0C, 32'h0);
    wr(`RCO_CTRL_ADR, 32'h7F);
    rd(`RCO_CTRL_ADR, 32'h1F);
    quiet(60);
    sel <= 4'hE;
    wr(`RCO_CTRL_ADR, 32'h80);
    sel <= 4'hF;
    rd(`RCO_CTRL_ADR, 32'h1F);
    rd(`RCO_STAT_ADR, 32'h0);
    wr(`RCO_SRC_ADR, 32'hFF);
    rd(`RCO_SRC_ADR, 32'h0F);
    $display("test regs done");
  endtask

  task automatic t_div();
    for (int dv = 0; dv < 8; dv++) begin
      wave(0, 2, dv);
    end
    $display("test divider done");
  endtask

  task automatic t_duty();
    for (int du = 0; du < 4; du++) begin
      wave(0, du, 2);
    end
    wave(0, 1, 0);
    wave(0, 0, 0);
    $display("test duty done");
  endtask

  task automatic t_src();
    for (int s = 0; s < 10; s++) begin
      wave(s, 2, 1);
    end
    cfg(10, 2, 1);
    quiet(300);
    $display("test source done");
  endtask

  task automatic t_live();
    int hi, per;
    cfg(0, 2, 1);
    meas(hi, per);
    wr(`RCO_CTRL_ADR, 32'h93);
    meas(hi, per);
    meas(hi, per);
    check(hi == 24 && per == 48, "divider change while on");
    meas(hi, per);
    wr(`RCO_CTRL_ADR, 32'h13);
    quiet(100);
    $display("test live change and stop done");
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_div();
    t_duty();
    t_src();
    t_live();
    check(tap_bad === 1'b0, "internal tap differs from pin");
    stop_test();
  end
endmodule
